// ===== hdl/fuse_trim_pkg.sv
// Package for the two-wire settings slave with fuse shadow
// Assumes one 40 MHz system clock; serial pins already synchronous
package fuse_trim_pkg;

    // ****************************************
    // Sizes and addresses
    // ****************************************
    localparam int          SPACE_BYTES         = 64;
    localparam logic [5:0]  LAST_INDEX          = 6'h3F;
    localparam logic [7:0]  WRITE_DEVICE_ADDRESS = 8'h8E;
    localparam logic [7:0]  READ_DEVICE_ADDRESS  = 8'h8F;
    localparam logic [5:0]  LOCK_REG_INDEX      = 6'h35;
    localparam int          PRIMARY_LOCK_BIT    = 7;
    localparam int          ALT_LOCK_LSB        = 4;
    localparam logic [7:0]  SHADOW_RESET_VALUE  = 8'h00;
    localparam logic [7:0]  FUSE_BLANK_VALUE    = 8'h00;
    localparam logic [3:0]  LOAD_CYCLES         = 4'h2;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_WORD  = 3'b011,
        ST_WDATA = 3'b010,
        ST_RDATA = 3'b110,
        ST_WAIT  = 3'b111
    } serial_state_t;

    typedef struct packed {
        logic       start_load;
        logic       burn;
    } fuse_cmd_t;

    typedef struct packed {
        logic       busy;
        logic       primary_lock;
        logic [2:0] alternate_set_lock_bits;
        logic [1:0] gain_set_select;
    } fuse_status_t;

endpackage

// ===== hdl/fuse_trim_serial_slave.sv
// Two-wire serial slave over a 64-byte settings shadow with fuse array
// Assumes serial pins sampled synchronously to clk_sys_in, open-drain outside
// Operation
// - Sixty-four settings bytes readable and writable by the serial master.
// - Answer address byte 8Eh for writes and 8Fh for reads.
// - In writes, the byte after the address sets the word pointer.
// - Any number of data bytes follow, each acknowledged.
// - Successive write bytes land at successive locations.
// - Word pointer increments during the acknowledge bit.
// - After read-address acknowledge, slave drives byte at word pointer.
// - Reads continue with incrementing word pointer while master acknowledges each byte.
// - Lock flag in register 35h set refuses further fuse programming.
// - Fuse bits only go from zero to one, never back.
// - Lock bits select the microphone gain set at start-up.
// - After power-on reset, fuses are copied into the shadow register.
// - Burn programs current shadow contents permanently into fuses.
`timescale 1ns/1ps
`default_nettype none

module fuse_trim_serial_slave (
    // Clock and reset
    input  wire logic                          clk_sys_in,
    input  wire logic                          rst_in,
    // Serial pins
    input  wire logic                          mode_serial_clock_pin_in,
    input  wire logic                          cancel_switch_serial_data_pin_in,
    output logic                               cancel_switch_serial_data_pin_oe_out,
    output logic                               cancel_switch_serial_data_pin_out,
    // Fuse control and status
    input  wire fuse_trim_pkg::fuse_cmd_t      fuse_cmd_in,
    output fuse_trim_pkg::fuse_status_t        fuse_status_out
);

    // ****************************************
    // Storage
    // ****************************************
    logic [7:0] shadow      [fuse_trim_pkg::SPACE_BYTES];
    logic [7:0] next_shadow [fuse_trim_pkg::SPACE_BYTES];
    // Unprogrammed cells read as zero
    logic [7:0] fuse        [fuse_trim_pkg::SPACE_BYTES] =
        '{default: fuse_trim_pkg::FUSE_BLANK_VALUE};
    logic [7:0] next_fuse   [fuse_trim_pkg::SPACE_BYTES];

    fuse_trim_pkg::serial_state_t state;
    fuse_trim_pkg::serial_state_t next_state;
    logic [5:0] word_pointer;
    logic [5:0] next_word_pointer;
    logic [7:0] shift;
    logic [7:0] next_shift;
    logic [3:0] bit_count;
    logic [3:0] next_bit_count;
    logic       ack_phase;
    logic       next_ack_phase;
    logic       sda_low;
    logic       next_sda_low;
    logic       scl_prev;
    logic       sda_prev;
    logic [3:0] load_count;
    logic [3:0] next_load_count;
    logic       primary_lock;
    logic       next_primary_lock;
    logic [2:0] alt_lock;
    logic [2:0] next_alt_lock;
    logic [1:0] gain_set;
    logic [1:0] next_gain_set;

    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;

    assign scl        = mode_serial_clock_pin_in;
    assign sda        = cancel_switch_serial_data_pin_in;
    assign scl_rise   = scl && !scl_prev;
    assign scl_fall   = !scl && scl_prev;
    assign start_cond = scl && scl_prev && sda_prev && !sda;
    assign stop_cond  = scl && scl_prev && !sda_prev && sda;

    // ****************************************
    // Serial protocol
    // ****************************************
    always_comb begin
        next_state        = state;
        next_word_pointer = word_pointer;
        next_shift        = shift;
        next_bit_count    = bit_count;
        next_ack_phase    = ack_phase;
        next_sda_low      = sda_low;
        next_shadow       = shadow;
        if (stop_cond) begin
            next_state   = fuse_trim_pkg::ST_IDLE;
            next_sda_low = 1'b0;
        end else if (start_cond) begin
            next_state     = fuse_trim_pkg::ST_ADDR;
            next_bit_count = 4'h0;
            next_ack_phase = 1'b0;
            next_sda_low   = 1'b0;
        end else if (state != fuse_trim_pkg::ST_IDLE && state != fuse_trim_pkg::ST_WAIT) begin
            if (scl_rise && !ack_phase) begin
                next_shift     = {shift[6:0], sda};
                next_bit_count = bit_count + 4'h1;
            end else if (scl_rise && ack_phase && state == fuse_trim_pkg::ST_RDATA
                         && sda) begin
                next_state = fuse_trim_pkg::ST_WAIT;
            end
            if (scl_fall && !ack_phase && bit_count == 4'h8) begin
                next_ack_phase = 1'b1;
                next_bit_count = 4'h0;
                next_sda_low   = 1'b0;
                unique case (state)
                    fuse_trim_pkg::ST_ADDR: begin
                        if (shift == fuse_trim_pkg::WRITE_DEVICE_ADDRESS) begin
                            next_sda_low = 1'b1;
                        end else if (shift == fuse_trim_pkg::READ_DEVICE_ADDRESS) begin
                            next_sda_low = 1'b1;
                        end else begin
                            next_state = fuse_trim_pkg::ST_WAIT;
                        end
                    end
                    fuse_trim_pkg::ST_WORD: begin
                        next_word_pointer = shift[5:0];
                        next_sda_low      = 1'b1;
                    end
                    fuse_trim_pkg::ST_WDATA: begin
                        next_shadow[word_pointer] = shift;
                        next_word_pointer = word_pointer + 6'h01;
                        next_sda_low      = 1'b1;
                    end
                    fuse_trim_pkg::ST_RDATA: begin
                        next_word_pointer = word_pointer + 6'h01;
                    end
                    default: begin
                        next_state = fuse_trim_pkg::ST_IDLE;
                    end
                endcase
            end else if (scl_fall && ack_phase) begin
                next_ack_phase = 1'b0;
                next_sda_low   = 1'b0;
                unique case (state)
                    fuse_trim_pkg::ST_ADDR: begin
                        if (shift[0]) begin
                            next_state = fuse_trim_pkg::ST_RDATA;
                            next_shift = shadow[word_pointer];
                            next_sda_low = !shadow[word_pointer][7];
                            next_bit_count = 4'h1;
                        end else begin
                            next_state = fuse_trim_pkg::ST_WORD;
                        end
                    end
                    fuse_trim_pkg::ST_WORD: next_state = fuse_trim_pkg::ST_WDATA;
                    fuse_trim_pkg::ST_WDATA: next_state = fuse_trim_pkg::ST_WDATA;
                    fuse_trim_pkg::ST_RDATA: begin
                        next_shift     = shadow[word_pointer];
                        next_sda_low   = !shadow[word_pointer][7];
                        next_bit_count = 4'h1;
                    end
                    default: next_state = fuse_trim_pkg::ST_IDLE;
                endcase
            end else if (scl_fall && state == fuse_trim_pkg::ST_RDATA && !ack_phase) begin
                next_sda_low = !shift[6];
                next_bit_count = bit_count + 4'h1;
                next_shift   = {shift[6:0], 1'b0};
            end
        end
        // Read shifting counts falls, not rises
        if (state == fuse_trim_pkg::ST_RDATA && scl_rise && !ack_phase) begin
            next_shift     = shift;
            next_bit_count = bit_count;
        end
        // Fuse load overrides the shadow
        if (load_count != 4'h0) begin
            next_shadow = fuse;
        end
    end

    // ****************************************
    // Fuse array, load and lock decode
    // ****************************************
    always_comb begin
        next_fuse         = fuse;
        next_load_count   = load_count;
        next_primary_lock = primary_lock;
        next_alt_lock     = alt_lock;
        next_gain_set     = gain_set;
        if (fuse_cmd_in.start_load) begin
            next_load_count = fuse_trim_pkg::LOAD_CYCLES;
        end else if (load_count != 4'h0) begin
            next_load_count = load_count - 4'h1;
        end
        if (load_count == 4'h1) begin
            next_primary_lock = fuse[fuse_trim_pkg::LOCK_REG_INDEX][fuse_trim_pkg::PRIMARY_LOCK_BIT];
            next_alt_lock = fuse[fuse_trim_pkg::LOCK_REG_INDEX][fuse_trim_pkg::ALT_LOCK_LSB +: 3];
            casez (next_alt_lock)
                3'b1??:  next_gain_set = 2'h3;
                3'b01?:  next_gain_set = 2'h2;
                3'b001:  next_gain_set = 2'h1;
                default: next_gain_set = 2'h0;
            endcase
        end
        if (fuse_cmd_in.burn && !fuse[fuse_trim_pkg::LOCK_REG_INDEX]
                [fuse_trim_pkg::PRIMARY_LOCK_BIT]) begin
            for (int i = 0; i < fuse_trim_pkg::SPACE_BYTES; i++) begin
                next_fuse[i] = fuse[i] | shadow[i];
            end
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            state        <= fuse_trim_pkg::ST_IDLE;
            word_pointer <= 6'h00;
            shift        <= 8'h00;
            bit_count    <= 4'h0;
            ack_phase    <= 1'b0;
            sda_low      <= 1'b0;
            scl_prev     <= 1'b1;
            sda_prev     <= 1'b1;
            load_count   <= fuse_trim_pkg::LOAD_CYCLES;
            primary_lock <= 1'b0;
            alt_lock     <= 3'h0;
            gain_set     <= 2'h0;
            for (int i = 0; i < fuse_trim_pkg::SPACE_BYTES; i++) begin
                shadow[i] <= fuse_trim_pkg::SHADOW_RESET_VALUE;
            end
        end else begin
            state        <= next_state;
            word_pointer <= next_word_pointer;
            shift        <= next_shift;
            bit_count    <= next_bit_count;
            ack_phase    <= next_ack_phase;
            sda_low      <= next_sda_low;
            scl_prev     <= scl;
            sda_prev     <= sda;
            load_count   <= next_load_count;
            primary_lock <= next_primary_lock;
            alt_lock     <= next_alt_lock;
            gain_set     <= next_gain_set;
            shadow       <= next_shadow;
        end
    end

    // Fuses keep their content through reset
    always_ff @(posedge clk_sys_in) begin
        fuse <= next_fuse;
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign cancel_switch_serial_data_pin_out    = 1'b0;
    assign cancel_switch_serial_data_pin_oe_out = !sda_low;
    assign fuse_status_out.busy                    = (load_count != 4'h0);
    assign fuse_status_out.primary_lock            = primary_lock;
    assign fuse_status_out.alternate_set_lock_bits = alt_lock;
    assign fuse_status_out.gain_set_select         = gain_set;

endmodule

`default_nettype wire

// ===== verification/fuse_trim_sva.sv
// Checker for the two-wire settings slave
// Assumes binding onto the slave top module
`timescale 1ns/1ps
`default_nettype none
module fuse_trim_sva (
    // Watched ports
    input wire logic                        clk_sys_in,
    input wire logic                        rst_in,
    input wire logic                        mode_serial_clock_pin_in,
    input wire logic                        cancel_switch_serial_data_pin_in,
    input wire logic                        cancel_switch_serial_data_pin_oe_out,
    input wire logic                        cancel_switch_serial_data_pin_out,
    input wire fuse_trim_pkg::fuse_cmd_t    fuse_cmd_in,
    input wire fuse_trim_pkg::fuse_status_t fuse_status_out
);
    wire       scl = mode_serial_clock_pin_in;
    wire       sda = cancel_switch_serial_data_pin_in;
    wire       oe  = cancel_switch_serial_data_pin_oe_out;
    wire       bsy = fuse_status_out.busy;
    wire [2:0] alt = fuse_status_out.alternate_set_lock_bits;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    chk_open_drain: assert property (cancel_switch_serial_data_pin_out == 1'b0)
        else $error("data pin driven high");
    chk_reset_quiet: assert property (disable iff (1'b0) rst_in ##1 rst_in |-> oe && bsy)
        else $error("reset state wrong");
    chk_load_busy: assert property (fuse_cmd_in.start_load |=> bsy)
        else $error("load did not raise busy");
    chk_busy_ends: assert property (bsy |-> ##[0:3] !bsy)
        else $error("busy too long");
    chk_busy_quiet: assert property (bsy |-> oe)
        else $error("driving while loading");
    chk_high_stable: assert property (scl && $past(scl) |-> $stable(oe))
        else $error("data moved with clock high");
    chk_after_fall: assert property ($changed(oe) |-> !scl && ($past(scl) || $past(scl, 2)
        || $past(scl, 3)))
        else $error("data moved away from clock fall");
    chk_start_free: assert property ($fell(sda) && scl && $past(scl) |-> oe)
        else $error("slave held data at start");
    chk_gain_pick: assert property (!bsy && fuse_status_out.primary_lock |->
        fuse_status_out.gain_set_select == (alt[2] ? 2'h3 : alt[1] ? 2'h2 : {1'b0, alt[0]}))
        else $error("gain set select wrong");
endmodule
bind fuse_trim_serial_slave fuse_trim_sva chk (.*);
`default_nettype wire

// ===== verification/serial_master_model.sv
// Serial master model driving clock and open-drain data
// Assumes the bench resolves the data wire with a pull-up
`timescale 1ns/1ps
`default_nettype none
module serial_master_model (
    // Clock and wire
    input  wire logic  clk_sys_in,
    input  wire logic  sda_in,
    // Pins and results
    output logic       scl_out = 1'b1,
    output logic       sda_low_out = 1'b0,
    output logic [7:0] res_out = 8'h00,
    output logic       res_valid_out = 1'b0
);
    task automatic tick;
        repeat (4) @(posedge clk_sys_in);
        #2;
    endtask
    task automatic clk_bit(input logic b, output logic r);
        sda_low_out = !b;
        tick;
        scl_out = 1'b1;
        tick;
        r = sda_in;
        scl_out = 1'b0;
    endtask
    task automatic start;
        sda_low_out = 1'b0;
        tick;
        scl_out = 1'b1;
        tick;
        sda_low_out = 1'b1;
        tick;
        scl_out = 1'b0;
    endtask
    task automatic stop;
        sda_low_out = 1'b1;
        tick;
        scl_out = 1'b1;
        tick;
        sda_low_out = 1'b0;
        tick;
    endtask
    // Byte out or in, then ack bit; nack ends a read
    task automatic xfer(input logic [7:0] d, input logic ack, input logic rd);
        logic       r;
        logic [7:0] v;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(d[i], r);
            v[i] = r;
        end
        clk_bit(ack, r);
        res_out = rd ? v : {7'h00, r};
        res_valid_out = 1'b1;
        @(posedge clk_sys_in);
        #2 res_valid_out = 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== verification/fuse_trim_serial_slave_test.sv
// Self-checking bench for the two-wire settings slave
// Assumes the master model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module fuse_trim_serial_slave_test;
    logic                        clk_sys = 1'b0;
    logic                        rst = 1'b1;
    fuse_trim_pkg::fuse_cmd_t    cmd = '0;
    fuse_trim_pkg::fuse_status_t st;
    logic                        oe, dout, scl, m_low, res_valid;
    logic [7:0]                  res;
    logic [7:0]                  d [3];
    logic [7:0]                  exp_q [$];
    int                          miscompares = 0;
    int                          comparisons = 0;
    int                          seed = 32'hb6ec;
    wire                         sda = !(m_low || (!oe && !dout));
    always #12.5 clk_sys = !clk_sys;
    fuse_trim_serial_slave dut (.clk_sys_in(clk_sys), .rst_in(rst),
        .mode_serial_clock_pin_in(scl), .cancel_switch_serial_data_pin_in(sda),
        .cancel_switch_serial_data_pin_oe_out(oe), .cancel_switch_serial_data_pin_out(dout),
        .fuse_cmd_in(cmd), .fuse_status_out(st));
    serial_master_model m (.clk_sys_in(clk_sys), .sda_in(sda), .scl_out(scl),
        .sda_low_out(m_low), .res_out(res), .res_valid_out(res_valid));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input logic [7:0] got, input logic [7:0] e);
        comparisons++;
        if (got !== e) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, e);
        end
    endtask
    task automatic wr(input logic [7:0] v, input logic [7:0] e);
        exp_q.push_back(e);
        m.xfer(v, 1'b1, 1'b0);
    endtask
    task automatic rd(input logic [7:0] e, input logic last);
        exp_q.push_back(e);
        m.xfer(8'hFF, last, 1'b1);
    endtask
    task automatic point(input logic [7:0] a);
        m.start;
        wr(8'h8E, 8'h00);
        wr(a, 8'h00);
    endtask
    task automatic pulse(input logic ld);
        @(posedge clk_sys);
        #2 cmd = {ld, !ld};
        @(posedge clk_sys);
        #2 cmd = '0;
    endtask
    task automatic wait_idle;
        for (int k = 0; k < 20 && st.busy !== 1'b0; k++) begin
            @(posedge clk_sys);
            #2;
        end
        check({7'h00, st.busy}, 8'h00);
    endtask
    task automatic print_verdict;
        if (miscompares == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ****************************************
    // Checking and sequence
    // ****************************************
    always @(posedge res_valid) check(res, exp_q.pop_front());
    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        print_verdict;
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        #2 rst = 1'b0;
        wait_idle;
        for (int i = 0; i < 3; i++) d[i] = $random(seed);
        point(8'h3E);
        for (int i = 0; i < 3; i++) wr(d[i], 8'h00);
        m.stop;
        m.start;
        wr(8'h90, 8'h01);
        m.stop;
        point(8'h3E);
        m.start;
        wr(8'h8F, 8'h00);
        rd(d[0], 1'b0);
        rd(d[1], 1'b0);
        rd(d[2], 1'b1);
        m.stop;
        point(8'h10);
        wr(8'hFF, 8'h00);
        m.stop;
        pulse(1'b0);
        point(8'h10);
        wr(8'h00, 8'h00);
        m.stop;
        point(8'h35);
        wr(8'hF0, 8'h00);
        m.stop;
        pulse(1'b0);
        point(8'h11);
        wr(8'h5A, 8'h00);
        m.stop;
        pulse(1'b0);
        pulse(1'b1);
        wait_idle;
        check({1'b0, st}, 8'h3F);
        point(8'h10);
        m.start;
        wr(8'h8F, 8'h00);
        rd(8'hFF, 1'b0);
        rd(8'h00, 1'b1);
        m.stop;
        print_verdict;
    end
endmodule
`default_nettype wire
